/* logic/tfs_map.svh */
// Register map, field positions, reset values and function codes
// Assumes: included by the package and by the top module of the block
`ifndef TFS_MAP_SVH
`define TFS_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TFS_OFF_CTRL_LOW 8'h00
`define TFS_OFF_CTRL_HIGH 8'h04
`define TFS_OFF_STATUS 8'h08
`define TFS_OFF_MASK 8'h0c
`define TFS_OFF_GR_B 8'h10
`define TFS_OFF_GR_C 8'h14
`define TFS_OFF_GR_D 8'h18

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define TFS_SEL_HI_MSB 7
`define TFS_SEL_HI_LSB 4
`define TFS_SEL_LO_MSB 3
`define TFS_SEL_LO_LSB 0
`define TFS_CTRL_RST 8'h00
`define TFS_GR_RST 16'h0000
`define TFS_EVT_RST 3'h0
`define TFS_ST_MATCH_LSB 0
`define TFS_ST_CAPT_LSB 4
`define TFS_PSC_UNDIV 3'h0

// ---------------------------------------------------------------
// Channel indices
// ---------------------------------------------------------------
`define TFS_CH_B 0
`define TFS_CH_C 1
`define TFS_CH_D 2
`define TFS_NCH 3

// ---------------------------------------------------------------
// Function code bits
// ---------------------------------------------------------------
`define TFS_CODE_CAPT 3
`define TFS_CODE_INIT 2
`define TFS_CODE_CASC 2
`define TFS_CODE_BOTH 1
`define TFS_CODE_FALL 0

`endif

/* logic/tfs_pkg.sv */
// Types shared by the function select block
// Assumes: the map header sits beside this file
package tfs_pkg;
`include "tfs_map.svh"

	// Four-bit function select code
	typedef logic [3:0] tfs_code_t;

	// Pin action at a compare match
	typedef enum logic [1:0] {
		TFS_ACT_OFF = 2'h0,
		TFS_ACT_LOW = 2'h1,
		TFS_ACT_HIGH = 2'h2,
		TFS_ACT_TGL = 2'h3
	} tfs_act_t;

	// Compare action held in the low two bits of a code
	function automatic tfs_act_t tfs_action(input tfs_code_t code);
		return tfs_act_t'(code[1:0]);
	endfunction : tfs_action

endpackage : tfs_pkg

/* logic/tfs_chan_if.sv */
// Carrier between the top and one general register channel
// Assumes: one instance per general register
`timescale 1ns/1ps
interface tfs_chan_if #(parameter int CW = 16);
	import tfs_pkg::*;
	tfs_code_t code;
	logic blocked;
	logic run;
	logic [CW-1:0] counter;
	logic [CW-1:0] gen_val;
	logic tick_ok;
	logic rise;
	logic fall;
	logic capture;
	logic match;
	logic pin_o;
	logic pin_oe_n;

	modport top (output code, blocked, run, counter, gen_val, tick_ok,
		rise, fall, input capture, match, pin_o, pin_oe_n);
	modport chan (input code, blocked, run, counter, gen_val, tick_ok,
		rise, fall, output capture, match, pin_o, pin_oe_n);
endinterface : tfs_chan_if

/* logic/tfs_sync.sv */
// Two-stage pin synchroniser with edge detection
// Assumes: pin_i may change at any time relative to pclk
`timescale 1ns/1ps
module tfs_sync (
	input wire logic pclk, // Peripheral clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic pin_i, // Raw capture pin
	output logic rise, // One-cycle rising edge pulse
	output logic fall // One-cycle falling edge pulse
);
	import tfs_pkg::*;

	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic last_q, last_d;

	// Next values: only the second stage feeds the edge detector
	always_comb begin
		meta_d = pin_i;
		sync_d = meta_q;
		last_d = sync_q;
	end

	// Register stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			last_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	// Edges from synchronised samples
	assign rise = sync_q & ~last_q;
	assign fall = ~sync_q & last_q;

endmodule : tfs_sync

/* logic/tfs_chan.sv */
// One general register: code decode, capture request, compare pin
// Assumes: counter and register value arrive through the carrier
`timescale 1ns/1ps
`include "tfs_map.svh"
module tfs_chan (
	input wire logic pclk, // Peripheral clock
	input wire logic presetn, // Asynchronous reset, active low
	tfs_chan_if.chan ch // Channel carrier
);
	import tfs_pkg::*;

	logic pin_q, pin_d;
	logic oe_n_q, oe_n_d;
	logic is_capt, edge_hit;

	// Decode, capture source and match
	always_comb begin
		is_capt = ch.code[`TFS_CODE_CAPT];
		if (ch.code[`TFS_CODE_BOTH])
			edge_hit = ch.rise | ch.fall;
		else if (ch.code[`TFS_CODE_FALL])
			edge_hit = ch.fall;
		else
			edge_hit = ch.rise;
		ch.capture = is_capt && !ch.blocked &&
			(ch.code[`TFS_CODE_CASC] ? ch.tick_ok : edge_hit);
		ch.match = !is_capt && !ch.blocked && ch.run &&
			(ch.counter == ch.gen_val);
	end

	// Pin level and enable next values
	always_comb begin
		pin_d = pin_q;
		oe_n_d = !(!is_capt && !ch.blocked &&
			tfs_action(ch.code) != TFS_ACT_OFF);
		if (!ch.run) begin
			pin_d = ch.code[`TFS_CODE_INIT];
		end else if (ch.match) begin
			unique case (tfs_action(ch.code))
				TFS_ACT_OFF: pin_d = pin_q;
				TFS_ACT_LOW: pin_d = 1'b0;
				TFS_ACT_HIGH: pin_d = 1'b1;
				TFS_ACT_TGL: pin_d = ~pin_q;
			endcase
		end
	end

	// Pin registers, updated the cycle after a match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else begin
			pin_q <= pin_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign ch.pin_o = pin_q;
	assign ch.pin_oe_n = oe_n_q;

endmodule : tfs_chan

/* logic/tfs_top.sv */
// Timer channel 0 function select for general registers B, C and D
// Assumes: APB master on pclk; counter and channel 1 tick supplied
// from the timer core; pins are sampled through synchronisers
//
// Functional notes
// - Low control bits 7..4 hold the register D select, reset 0, RW.
// - Low control bits 3..0 hold the register C select, reset 0, RW.
// - Codes 0000-0011 compare with pin starting 0: off, 0, 1, toggle.
// - Codes 0100-0111 compare with pin starting 1: off, 0, 1, toggle.
// - Code 1000 captures on rise, 1001 on fall, 101X on both edges.
// - Codes 11XX capture on each count step of the channel 1 counter.
// - Undivided channel 1 prescale disables that cascade capture.
// - Buffer mode B makes register D a plain buffer with no function.
// - The high control B select uses the same codes on the B pin.
// - The initial pin level is driven only while the counter stops.
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "tfs_map.svh"
module tfs_top #(
	parameter int CW = 16 // Counter and general register width
) (
	input wire logic pclk, // Peripheral clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic [CW-1:0] ch0_counter, // Channel 0 counter
	input wire logic counter_run, // Channel 0 run bit
	input wire logic buffer_mode_b, // Register B/D buffer mode
	input wire logic [2:0] prescale_select, // Channel 1 prescale
	input wire logic ch1_count_tick, // Channel 1 counted up or down
	input wire logic [`TFS_NCH-1:0] pin_i, // Pins B, C, D in
	output logic [`TFS_NCH-1:0] pin_o, // Pins B, C, D out
	output logic [`TFS_NCH-1:0] pin_oe_n, // Low while driving
	output logic irq // Level interrupt
);
	import tfs_pkg::*;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [7:0] ctrl_low_q, ctrl_low_d;
	logic [7:0] ctrl_high_q, ctrl_high_d;
	logic [`TFS_NCH-1:0] st_match_q, st_match_d;
	logic [`TFS_NCH-1:0] st_capt_q, st_capt_d;
	logic [`TFS_NCH-1:0] mk_match_q, mk_match_d;
	logic [`TFS_NCH-1:0] mk_capt_q, mk_capt_d;
	logic [CW-1:0] gr_q [`TFS_NCH];
	logic [CW-1:0] gr_d [`TFS_NCH];
	logic [31:0] rdata_q, rdata_d;
	logic err_q, err_d;

	logic setup, wr_acc;
	logic [`TFS_NCH-1:0] capt_ev, match_ev;
	logic [`TFS_NCH-1:0] rise, fall;
	tfs_code_t code [`TFS_NCH];
	logic tick_ok;

	tfs_chan_if #(.CW(CW)) ch_if [`TFS_NCH] ();

	// ---------------------------------------------------------------
	// Function select fields
	// ---------------------------------------------------------------
	always_comb begin
		code[`TFS_CH_B] = ctrl_high_q[`TFS_SEL_HI_MSB:`TFS_SEL_HI_LSB];
		code[`TFS_CH_C] = ctrl_low_q[`TFS_SEL_LO_MSB:`TFS_SEL_LO_LSB];
		code[`TFS_CH_D] = ctrl_low_q[`TFS_SEL_HI_MSB:`TFS_SEL_HI_LSB];
	end

	// Cascade tick valid only when channel 1 is prescaled
	assign tick_ok = ch1_count_tick &&
		(prescale_select != `TFS_PSC_UNDIV);

	// ---------------------------------------------------------------
	// Channels
	// ---------------------------------------------------------------
	for (genvar i = 0; i < `TFS_NCH; i++) begin : g_ch
		// Pin synchroniser
		tfs_sync u_sync (
			.pclk(pclk),
			.presetn(presetn),
			.pin_i(pin_i[i]),
			.rise(rise[i]),
			.fall(fall[i])
		);

		// Carrier drive
		assign ch_if[i].code = code[i];
		assign ch_if[i].blocked = (i == `TFS_CH_D) && buffer_mode_b;
		assign ch_if[i].run = counter_run;
		assign ch_if[i].counter = ch0_counter;
		assign ch_if[i].gen_val = gr_q[i];
		assign ch_if[i].tick_ok = tick_ok;
		assign ch_if[i].rise = rise[i];
		assign ch_if[i].fall = fall[i];

		// Decode and pin logic
		tfs_chan u_chan (
			.pclk(pclk),
			.presetn(presetn),
			.ch(ch_if[i])
		);

		assign capt_ev[i] = ch_if[i].capture;
		assign match_ev[i] = ch_if[i].match;
		assign pin_o[i] = ch_if[i].pin_o;
		assign pin_oe_n[i] = ch_if[i].pin_oe_n;
	end

	// ---------------------------------------------------------------
	// APB slave: data latched in setup, one wait-free access phase
	// ---------------------------------------------------------------
	assign setup = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign pready = psel && penable;
	assign prdata = rdata_q;
	assign pslverr = err_q;

	// Read mux and decode error, evaluated in the setup cycle
	always_comb begin
		rdata_d = rdata_q;
		err_d = err_q;
		if (setup) begin
			rdata_d = 32'h0000_0000;
			err_d = 1'b0;
			unique case (paddr)
				`TFS_OFF_CTRL_LOW: rdata_d[7:0] = ctrl_low_q;
				`TFS_OFF_CTRL_HIGH: rdata_d[7:0] = ctrl_high_q;
				`TFS_OFF_STATUS: begin
					rdata_d[`TFS_ST_MATCH_LSB +: `TFS_NCH] = st_match_q;
					rdata_d[`TFS_ST_CAPT_LSB +: `TFS_NCH] = st_capt_q;
				end
				`TFS_OFF_MASK: begin
					rdata_d[`TFS_ST_MATCH_LSB +: `TFS_NCH] = mk_match_q;
					rdata_d[`TFS_ST_CAPT_LSB +: `TFS_NCH] = mk_capt_q;
				end
				`TFS_OFF_GR_B: rdata_d[CW-1:0] = gr_q[`TFS_CH_B];
				`TFS_OFF_GR_C: rdata_d[CW-1:0] = gr_q[`TFS_CH_C];
				`TFS_OFF_GR_D: rdata_d[CW-1:0] = gr_q[`TFS_CH_D];
				default: err_d = 1'b1;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Register writes, capture loads and sticky events
	// ---------------------------------------------------------------
	always_comb begin
		ctrl_low_d = ctrl_low_q;
		ctrl_high_d = ctrl_high_q;
		mk_match_d = mk_match_q;
		mk_capt_d = mk_capt_q;
		st_match_d = st_match_q;
		st_capt_d = st_capt_q;
		for (int i = 0; i < `TFS_NCH; i++)
			gr_d[i] = gr_q[i];
		if (wr_acc) begin
			unique case (paddr)
				`TFS_OFF_CTRL_LOW: ctrl_low_d = pwdata[7:0];
				`TFS_OFF_CTRL_HIGH: ctrl_high_d = pwdata[7:0];
				`TFS_OFF_STATUS: begin
					st_match_d = st_match_q &
						~pwdata[`TFS_ST_MATCH_LSB +: `TFS_NCH];
					st_capt_d = st_capt_q &
						~pwdata[`TFS_ST_CAPT_LSB +: `TFS_NCH];
				end
				`TFS_OFF_MASK: begin
					mk_match_d = pwdata[`TFS_ST_MATCH_LSB +: `TFS_NCH];
					mk_capt_d = pwdata[`TFS_ST_CAPT_LSB +: `TFS_NCH];
				end
				`TFS_OFF_GR_B: gr_d[`TFS_CH_B] = pwdata[CW-1:0];
				`TFS_OFF_GR_C: gr_d[`TFS_CH_C] = pwdata[CW-1:0];
				`TFS_OFF_GR_D: gr_d[`TFS_CH_D] = pwdata[CW-1:0];
				default: ;
			endcase
		end
		// Hardware events win over a same-cycle clear or write
		st_match_d = st_match_d | match_ev;
		st_capt_d = st_capt_d | capt_ev;
		for (int i = 0; i < `TFS_NCH; i++)
			if (capt_ev[i])
				gr_d[i] = ch0_counter;
	end

	// Register update
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_low_q <= `TFS_CTRL_RST;
			ctrl_high_q <= `TFS_CTRL_RST;
			mk_match_q <= `TFS_EVT_RST;
			mk_capt_q <= `TFS_EVT_RST;
			st_match_q <= `TFS_EVT_RST;
			st_capt_q <= `TFS_EVT_RST;
			for (int i = 0; i < `TFS_NCH; i++)
				gr_q[i] <= CW'(`TFS_GR_RST);
			rdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else begin
			ctrl_low_q <= ctrl_low_d;
			ctrl_high_q <= ctrl_high_d;
			mk_match_q <= mk_match_d;
			mk_capt_q <= mk_capt_d;
			st_match_q <= st_match_d;
			st_capt_q <= st_capt_d;
			for (int i = 0; i < `TFS_NCH; i++)
				gr_q[i] <= gr_d[i];
			rdata_q <= rdata_d;
			err_q <= err_d;
		end
	end

	// Interrupt while any unmasked status bit is set
	assign irq = |(st_match_q & mk_match_q) | |(st_capt_q & mk_capt_q);

endmodule : tfs_top

/* verification/tfs_pin_model.sv */
// Model of the outside world on the three timer pins
// Assumes: ext is the level driven from outside on undriven pins
`timescale 1ns/1ps
module tfs_pin_model (
	input wire logic [2:0] pin_o, // Device pin levels
	input wire logic [2:0] pin_oe_n, // Low while the device drives
	input wire logic [2:0] ext, // Level from outside
	output logic [2:0] pin_i // Resolved wire level
);
	// ----------
	// Wire resolution
	// ----------
	// The device wins where it drives, elsewhere the outside level shows
	assign pin_i = (pin_o & ~pin_oe_n) | (ext & pin_oe_n);
endmodule : tfs_pin_model

/* verification/tfs_checker.sv */
// Port-level checks of the function select top
// Assumes: bound onto tfs_top; map header on the include path
`timescale 1ns/1ps
`include "tfs_map.svh"
module tfs_checker (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire logic counter_run, // Run bit
	input wire logic buffer_mode_b, // Buffer mode
	input wire logic [`TFS_NCH-1:0] pin_o, // Pin levels
	input wire logic [`TFS_NCH-1:0] pin_oe_n, // Pin enables
	input wire logic irq // Interrupt
);
	// ----------
	// Bus and pin relations
	// ----------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Access phase and accepted write
	wire logic acc = psel && penable;
	wire logic wacc = acc && pwrite;

	a_ready_zero_wait: assert property (pready == acc)
		else $error("pready differs from the access phase");
	a_map_no_err: assert property (acc && paddr[1:0] == 2'h0 &&
		paddr <= `TFS_OFF_GR_D |-> !pslverr)
		else $error("error on a mapped register");
	a_unmap_err: assert property (acc && paddr > `TFS_OFF_GR_D |->
		pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_upper_zero: assert property (acc && !pwrite |->
		prdata[31:16] == 16'h0)
		else $error("upper read bits not zero");
	a_rdata_stands: assert property (!(psel && !penable) |=> $stable(prdata))
		else $error("read data moved outside a setup edge");
	a_err_stands: assert property (!(psel && !penable) |=> $stable(pslverr))
		else $error("error flag moved outside a setup edge");
	a_stop_pins: assert property ((!counter_run && !wacc &&
		$stable(buffer_mode_b))[*4] |-> $stable(pin_o) && $stable(pin_oe_n))
		else $error("pin moved while the counter was stopped");
	a_d_blocked: assert property (buffer_mode_b[*2] |->
		pin_oe_n[`TFS_CH_D])
		else $error("register D pin driven in buffer mode");

	// Main scenarios seen
	c_unmapped: cover property (acc && pslverr);
	c_irq: cover property ($rose(irq));
	c_match_pin: cover property (counter_run && $changed(pin_o));
	c_buffer: cover property (buffer_mode_b && acc);
endmodule : tfs_checker

bind tfs_top tfs_checker u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.counter_run(counter_run), .buffer_mode_b(buffer_mode_b),
	.pin_o(pin_o), .pin_oe_n(pin_oe_n), .irq(irq));

/* verification/testbench.sv */
// Self-checking bench of the function select block
// Assumes: one 250 MHz clock; pins resolved by the pin model
`timescale 1ns/1ps
`include "tfs_map.svh"
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tick = 1'b0;
	logic counter_run = 1'b0, buffer_mode_b = 1'b0;
	logic pready, pslverr, irq;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rs = 32'h0000c94b;
	logic [15:0] cnt = 16'h0000;
	logic [2:0] psc = 3'h0, ext = 3'h0, pin_i, pin_o, pin_oe_n;
	int n_errors = 0, num_checks = 0;

	// ----------
	// Clock, design and pins
	// ----------
	always #2 pclk = ~pclk;
	tfs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ch0_counter(cnt), .counter_run(counter_run),
		.buffer_mode_b(buffer_mode_b), .prescale_select(psc),
		.ch1_count_tick(tick), .pin_i(pin_i), .pin_o(pin_o),
		.pin_oe_n(pin_oe_n), .irq(irq));
	tfs_pin_model PINS (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext(ext),
		.pin_i(pin_i));

	// ----------
	// Helpers
	// ----------
	// Xorshift source of stimulus
	function logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	// Pin level after one match, from the code alone
	function logic exp_pin(input logic [3:0] c);
		case (c[1:0])
			2'h1: return 1'b0;
			2'h2: return 1'b1;
			2'h3: return ~c[2];
			default: return c[2];
		endcase
	endfunction : exp_pin
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
			n_errors++;
		end
	endtask : chk
	// One APB transfer, held until pready is seen at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk(32'(e), 32'(a > `TFS_OFF_GR_D));
	endtask : rd
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task finish_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test

	// Watchdog far beyond the length of the tests
	initial begin
		#100000;
		n_errors++;
		finish_test();
	end

	// ----------
	// Tests
	// ----------
	initial begin
		logic [31:0] d;
		logic [15:0] v;
		logic [3:0] c;
		cyc(16);
		presetn <= 1'b1;
		for (int a = 0; a <= 32; a += 4) rd(8'(a), 32'h0);
		repeat (8) begin
			d = rnd();
			wr(`TFS_OFF_CTRL_LOW, d);
			wr(`TFS_OFF_CTRL_HIGH, d);
			rd(`TFS_OFF_CTRL_LOW, d & 32'hff);
			rd(`TFS_OFF_CTRL_HIGH, d & 32'hff);
		end
		wr(`TFS_OFF_CTRL_HIGH, 32'h0);
		$display("test registers done");
		for (int i = 0; i < 8; i++) begin
			c = 4'(i);
			d = rnd();
			v = (d[15:0] & 16'h7fff) | 16'h0100;
			wr(`TFS_OFF_CTRL_LOW, {28'h0, c});
			wr(`TFS_OFF_GR_C, {16'h0, v});
			cnt <= v - 16'h0002;
			wr(`TFS_OFF_STATUS, 32'h77);
			@(negedge pclk);
			chk(32'(pin_oe_n[1]), 32'(c[1:0] == 2'h0));
			if (c[1:0] != 2'h0) chk(32'(pin_o[1]), 32'(c[2]));
			cyc(1);
			counter_run <= 1'b1;
			cyc(2);
			cnt <= v;
			cyc(1);
			cnt <= v + 16'h0001;
			cyc(2);
			@(negedge pclk);
			if (c[1:0] != 2'h0) chk(32'(pin_o[1]), 32'(exp_pin(c)));
			rd(`TFS_OFF_STATUS, 32'h2);
			chk(32'(irq), 32'h0);
			wr(`TFS_OFF_MASK, 32'h2);
			@(negedge pclk);
			chk(32'(irq), 32'h1);
			wr(`TFS_OFF_STATUS, 32'h2);
			@(negedge pclk);
			chk(32'(irq), 32'h0);
			wr(`TFS_OFF_MASK, 32'h0);
			counter_run <= 1'b0;
		end
		$display("test compare done");
		wr(`TFS_OFF_CTRL_LOW, 32'h0);
		for (int i = 8; i < 12; i++) begin
			c = 4'(i);
			d = rnd();
			wr(`TFS_OFF_CTRL_HIGH, {24'h0, c, 4'h0});
			wr(`TFS_OFF_GR_B, 32'h0);
			cnt <= d[15:0];
			cyc(1);
			ext[0] <= 1'b1;
			cyc(5);
			rd(`TFS_OFF_GR_B, {16'h0, c == 4'h9 ? 16'h0 : d[15:0]});
			cnt <= d[31:16];
			ext[0] <= 1'b0;
			cyc(5);
			rd(`TFS_OFF_GR_B, {16'h0, c == 4'h8 ? d[15:0] : d[31:16]});
		end
		$display("test capture done");
		wr(`TFS_OFF_CTRL_HIGH, 32'hc0);
		wr(`TFS_OFF_CTRL_LOW, 32'hc0);
		for (int i = 0; i < 3; i++) begin
			d = rnd();
			psc <= i == 0 ? 3'h0 : d[18:16] | 3'h1;
			buffer_mode_b <= i == 2;
			wr(`TFS_OFF_GR_D, 32'h0);
			wr(`TFS_OFF_GR_B, 32'h0);
			cnt <= d[15:0];
			tick <= 1'b1;
			cyc(1);
			tick <= 1'b0;
			cyc(3);
			rd(`TFS_OFF_GR_D, {16'h0, i == 1 ? d[15:0] : 16'h0});
			rd(`TFS_OFF_GR_B, {16'h0, i == 0 ? 16'h0 : d[15:0]});
		end
		// Buffer mode must keep a driving compare code off the D pin
		wr(`TFS_OFF_CTRL_LOW, 32'h10);
		cyc(2);
		@(negedge pclk);
		chk(32'(pin_oe_n[2]), 32'h1);
		cyc(1);
		buffer_mode_b <= 1'b0;
		cyc(2);
		@(negedge pclk);
		chk(32'(pin_oe_n[2]), 32'h0);
		$display("test cascade done");
		finish_test();
	end
endmodule : testbench
